// [rtl/wdr_watchdog_reset_control.sv]
// Watchdog timer, key-protected control registers and reset source sequencing.
// Assumes the CPU core gives one-cycle instruction strobes on i_clock and that the
// slow oscillator, shared pin and configuration strap arrive asynchronously.
`timescale 1ns/100ps

module wdr_watchdog_reset_control (
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_n,
	// Register bus
	input  wire wdr_pkg::wdr_avs_req_s i_avs,
	output      wdr_pkg::wdr_avs_rsp_s o_avs,
	// CPU events
	input  wire wdr_pkg::wdr_cpu_evt_s i_cpu_evt,
	// Other reset sources
	input  wire logic                  i_brownout_event,
	input  wire logic                  i_level_code_event,
	// Pins and straps
	input  wire logic                  i_slow_internal_osc,
	input  wire logic                  i_external_clear_pin_n,
	input  wire logic [1:0]            i_pin_config,
	// Reset outputs
	output      logic                  o_device_reset,
	output      logic                  o_pc_sp_clear,
	output      logic                  o_cpu_hold,
	output      logic                  o_port_preset,
	output      logic                  o_shared_pin_is_reset,
	// Status
	output      logic                  o_expiry_flag,
	output      logic                  o_power_down_flag
);
	import wdr_pkg::*;

	// ==========================================================================
	// Input synchronisers
	logic       osc_s1;
	logic       osc_s2;
	logic       osc_s3;
	logic       pin_s1;
	logic       pin_s2;
	logic [1:0] cfg_s1;
	logic [1:0] cfg_s2;
	logic       tick;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
			osc_s3 <= 1'b0;
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
			cfg_s1 <= 2'h0;
			cfg_s2 <= 2'h0;
		end else begin
			osc_s1 <= i_slow_internal_osc;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			pin_s1 <= i_external_clear_pin_n;
			pin_s2 <= pin_s1;
			cfg_s1 <= i_pin_config;
			cfg_s2 <= cfg_s1;
		end
	end

	// Rising edge of the slow oscillator paces every slow count
	assign tick = osc_s2 & ~osc_s3;

	// ==========================================================================
	// Registers and decoded state
	logic [7:0]           watchdog_control;
	logic [7:0]           pin_function_key;
	logic                 watchdog_key_fault_flag;
	logic                 level_code_fault_flag;
	logic                 brownout_flag;
	logic                 pin_key_fault_flag;
	logic                 expiry_flag;
	logic                 power_down_flag;
	wdr_power_e           power_mode;
	logic [WDT_CNT_W-1:0] wdt_count;
	logic [7:0]           soft_ticks;
	logic                 pend_wdt_key;
	logic                 pend_pin_key;
	logic [11:0]          release_count;
	logic                 ack;
	logic [31:0]          readdata;

	logic [4:0] watchdog_enable_key;
	logic [2:0] period_select;
	logic       wdt_enabled;
	logic       wdt_key_bad;
	logic       pin_key_bad;
	logic       pin_is_reset;
	logic       ext_active;
	logic       overflow;
	logic       soft_fire;
	logic       full_reset;
	logic       warm_wake;
	logic       wr_take;
	logic       rd_take;

	assign watchdog_enable_key = watchdog_control[KEY_MSB:KEY_LSB];
	assign period_select       = watchdog_control[PERIOD_MSB:PERIOD_LSB];
	assign wdt_enabled         = (watchdog_enable_key == KEY_ENABLE);
	// Checked every cycle, so a value corrupted by noise is caught as well as a write
	assign wdt_key_bad         = !wdt_enabled && (watchdog_enable_key != KEY_DISABLE);
	assign pin_key_bad         = (pin_function_key != PIN_CODE_GPIO) &&
	                             (pin_function_key != PIN_CODE_RESET);

	// Fixed options take either valid code; register option decodes it
	always_comb begin
		if (cfg_s2 == CFG_ALWAYS_GPIO) begin
			pin_is_reset = 1'b0;
		end else if (cfg_s2 == CFG_ALWAYS_RESET) begin
			pin_is_reset = 1'b1;
		end else begin
			pin_is_reset = (pin_function_key == PIN_CODE_RESET);
		end
	end

	assign ext_active = pin_is_reset && !pin_s2;

	// Overflow only possible while enabled, since the counter is held otherwise
	assign overflow   = wdt_enabled && tick &&
	                    (wdt_count == wdr_terminal(period_select));
	assign soft_fire  = (pend_wdt_key || pend_pin_key) && tick &&
	                    (soft_ticks == SOFT_RESET_TICKS - 8'h01);
	assign full_reset = soft_fire || (overflow && power_mode == PM_RUN);
	assign warm_wake  = overflow && (power_mode == PM_HALTED);

	// ==========================================================================
	// Avalon-MM slave: one wait cycle per access
	assign wr_take = i_avs.write && ack;
	assign rd_take = i_avs.read && !ack;
	assign o_avs   = '{readdata: readdata, waitrequest: (i_avs.read || i_avs.write) && !ack};

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ack <= 1'b0;
		end else begin
			ack <= (i_avs.read || i_avs.write) && !ack;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (rd_take) begin
			unique case (i_avs.address)
				ADDR_WDT_CTRL: readdata <= {24'h00_0000, watchdog_control};
				ADDR_FLAGS:    readdata <= {28'h000_0000, pin_key_fault_flag, brownout_flag,
				                            level_code_fault_flag,
				                            watchdog_key_fault_flag};
				ADDR_PIN_KEY:  readdata <= {24'h00_0000, pin_function_key};
				ADDR_STATUS:   readdata <= {28'h000_0000, pin_is_reset,
				                            power_mode == PM_HALTED, power_down_flag,
				                            expiry_flag};
				default:       readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================================
	// Watchdog control register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			watchdog_control <= WDT_CTRL_POR;
		end else if (full_reset) begin
			watchdog_control <= WDT_CTRL_POR;
		end else if (wr_take && i_avs.address == ADDR_WDT_CTRL && i_avs.byteenable[0]) begin
			watchdog_control <= i_avs.writedata[7:0];
		end
	end

	// ==========================================================================
	// Pin function key register
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_function_key <= PIN_KEY_POR;
		end else if (full_reset || ext_active) begin
			// Halted watchdog wake keeps the key
			pin_function_key <= PIN_KEY_POR;
		end else if (wr_take && i_avs.address == ADDR_PIN_KEY && i_avs.byteenable[0]) begin
			pin_function_key <= i_avs.writedata[7:0];
		end
	end

	// ==========================================================================
	// Watchdog counter
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wdt_count <= '0;
		end else if (!wdt_enabled) begin
			wdt_count <= '0;
		end else if (i_cpu_evt.watchdog_clear_instr || i_cpu_evt.halt_instr || ext_active) begin
			wdt_count <= '0;
		end else if (overflow || full_reset) begin
			wdt_count <= '0;
		end else if (tick) begin
			wdt_count <= wdt_count + 18'h00001;
		end
	end

	// ==========================================================================
	// Soft reset delay
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_wdt_key <= 1'b0;
			pend_pin_key <= 1'b0;
		end else if (soft_fire) begin
			pend_wdt_key <= 1'b0;
			pend_pin_key <= 1'b0;
		end else begin
			// Latched so a key that flips back still completes its reset
			if (wdt_key_bad) begin
				pend_wdt_key <= 1'b1;
			end
			if (pin_key_bad) begin
				pend_pin_key <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			soft_ticks <= 8'h00;
		end else if (!(pend_wdt_key || pend_pin_key) || soft_fire) begin
			soft_ticks <= 8'h00;
		end else if (tick) begin
			soft_ticks <= soft_ticks + 8'h01;
		end
	end

	// ==========================================================================
	// Reset cause flags: hardware set wins over a software write
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			watchdog_key_fault_flag <= 1'b0;
			level_code_fault_flag   <= 1'b0;
			brownout_flag           <= 1'b0;
			pin_key_fault_flag      <= 1'b0;
		end else begin
			if (wr_take && i_avs.address == ADDR_FLAGS && i_avs.byteenable[0]) begin
				watchdog_key_fault_flag <= i_avs.writedata[FLAG_WDT_KEY];
				level_code_fault_flag   <= i_avs.writedata[FLAG_LEVEL];
				brownout_flag           <= i_avs.writedata[FLAG_BROWNOUT];
				pin_key_fault_flag      <= i_avs.writedata[FLAG_PIN_KEY];
			end
			if (soft_fire && pend_wdt_key) begin
				watchdog_key_fault_flag <= 1'b1;
			end
			if (soft_fire && pend_pin_key) begin
				pin_key_fault_flag <= 1'b1;
			end
			if (i_level_code_event) begin
				level_code_fault_flag <= 1'b1;
			end
			if (i_brownout_event) begin
				brownout_flag <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Power mode and status flags
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			power_mode <= PM_RUN;
		end else if (full_reset || warm_wake || ext_active || i_cpu_evt.wake_event) begin
			power_mode <= PM_RUN;
		end else if (i_cpu_evt.halt_instr) begin
			power_mode <= PM_HALTED;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			expiry_flag <= 1'b0;
		end else if (overflow) begin
			// Overflow wins over a halt in the same cycle
			expiry_flag <= 1'b1;
		end else if (i_cpu_evt.halt_instr) begin
			expiry_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			power_down_flag <= 1'b0;
		end else if (i_cpu_evt.halt_instr || warm_wake) begin
			power_down_flag <= 1'b1;
		end else if (i_cpu_evt.watchdog_clear_instr) begin
			power_down_flag <= 1'b0;
		end
	end

	// ==========================================================================
	// Pin reset hold and release delay
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			release_count <= 12'h000;
		end else if (ext_active) begin
			release_count <= PIN_RELEASE_COUNT;
		end else if (release_count != 12'h000) begin
			release_count <= release_count - 12'h001;
		end
	end

	// ==========================================================================
	// Output registers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_device_reset        <= 1'b0;
			o_pc_sp_clear         <= 1'b0;
			o_cpu_hold            <= 1'b1;
			o_port_preset         <= 1'b1;
			o_shared_pin_is_reset <= 1'b0;
			o_expiry_flag         <= 1'b0;
			o_power_down_flag     <= 1'b0;
		end else begin
			o_device_reset        <= full_reset;
			o_pc_sp_clear         <= warm_wake;
			// Hold keeps watchdog_control intact but resets the pin function key; only the program counter restarts
			o_cpu_hold            <= ext_active || (release_count != 12'h000);
			o_port_preset         <= 1'b0;
			o_shared_pin_is_reset <= pin_is_reset;
			o_expiry_flag         <= expiry_flag;
			o_power_down_flag     <= power_down_flag;
		end
	end

endmodule

// [rtl/wdr_pkg.sv]
// Constants, register map and carrier types for the watchdog and reset control block.
// Assumes a 25 MHz system clock and a slow oscillator near 32 kHz sampled as a plain input.
package wdr_pkg;

	// ==========================================================================
	// Register map (byte addresses, one 32-bit word each)
	localparam logic [3:0] ADDR_WDT_CTRL = 4'h0;
	localparam logic [3:0] ADDR_FLAGS    = 4'h4;
	localparam logic [3:0] ADDR_PIN_KEY  = 4'h8;
	localparam logic [3:0] ADDR_STATUS   = 4'hC;

	// ==========================================================================
	// Reset values and codes
	localparam logic [7:0] WDT_CTRL_POR   = 8'h53;
	localparam logic [7:0] PIN_KEY_POR    = 8'h55;
	localparam logic [4:0] KEY_ENABLE     = 5'h0A;
	localparam logic [4:0] KEY_DISABLE    = 5'h15;
	localparam logic [7:0] PIN_CODE_GPIO  = 8'h55;
	localparam logic [7:0] PIN_CODE_RESET = 8'hAA;

	// ==========================================================================
	// Field positions
	localparam int KEY_MSB       = 7;
	localparam int KEY_LSB       = 3;
	localparam int PERIOD_MSB    = 2;
	localparam int PERIOD_LSB    = 0;
	localparam int FLAG_WDT_KEY  = 0;
	localparam int FLAG_LEVEL    = 1;
	localparam int FLAG_BROWNOUT = 2;
	localparam int FLAG_PIN_KEY  = 3;
	localparam int ST_EXPIRY     = 0;
	localparam int ST_POWER_DOWN = 1;
	localparam int ST_HALTED     = 2;
	localparam int ST_PIN_RESET  = 3;

	// ==========================================================================
	// Shared pin configuration option codes
	localparam logic [1:0] CFG_ALWAYS_GPIO  = 2'h0;
	localparam logic [1:0] CFG_ALWAYS_RESET = 2'h1;

	// ==========================================================================
	// Timing
	localparam int          SLOW_OSC_HZ          = 32000;
	localparam int          CLOCK_PERIOD_NS      = 40;
	localparam int          PIN_RELEASE_DELAY_NS = 100000;
	localparam int          PIN_RELEASE_CYCLES   =
		(PIN_RELEASE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam logic [11:0] PIN_RELEASE_COUNT    = 12'(PIN_RELEASE_CYCLES);
	localparam logic [7:0]  SOFT_RESET_TICKS     = 8'h10;
	localparam int          WDT_CNT_W            = 18;

	// ==========================================================================
	// Types
	typedef enum logic {
		PM_RUN,
		PM_HALTED
	} wdr_power_e;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} wdr_avs_req_s;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} wdr_avs_rsp_s;

	typedef struct packed {
		logic watchdog_clear_instr;
		logic halt_instr;
		logic wake_event;
	} wdr_cpu_evt_s;

	// Last count before overflow for each period select code
	function automatic logic [WDT_CNT_W-1:0] wdr_terminal(input logic [2:0] period_select);
		logic [WDT_CNT_W-1:0] t;
		t = 18'h3FFFF;
		unique case (period_select)
			3'h0: t = 18'h000FF;
			3'h1: t = 18'h003FF;
			3'h2: t = 18'h00FFF;
			3'h3: t = 18'h03FFF;
			3'h4: t = 18'h07FFF;
			3'h5: t = 18'h0FFFF;
			3'h6: t = 18'h1FFFF;
			3'h7: t = 18'h3FFFF;
		endcase
		return t;
	endfunction

endpackage

// [bench/wdr_monitor.sv]
// Checker for the watchdog and reset control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module wdr_monitor
	import wdr_pkg::*;
(
	// Clock and reset
	input wire logic                  i_clock,
	input wire logic                  i_rst_n,
	// Inputs
	input wire wdr_pkg::wdr_cpu_evt_s i_cpu_evt,
	input wire logic                  i_external_clear_pin_n,
	input wire logic [1:0]            i_pin_config,
	// Outputs
	input wire logic                  o_device_reset,
	input wire logic                  o_pc_sp_clear,
	input wire logic                  o_cpu_hold,
	input wire logic                  o_port_preset,
	input wire logic                  o_shared_pin_is_reset,
	input wire logic                  o_expiry_flag,
	input wire logic                  o_power_down_flag
);
	// ======
	// Sequences
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	sequence s_halt;
		i_cpu_evt.halt_instr;
	endsequence
	// Pin sync lag is two flops plus the output register
	sequence s_pin_low;
		(!i_external_clear_pin_n && o_shared_pin_is_reset) [*4];
	endsequence
	sequence s_release;
		$rose(i_external_clear_pin_n) && o_cpu_hold;
	endsequence

	// ======
	// Properties
	pulse_once_a: assert property (o_device_reset |=> !o_device_reset)
		else $error("device reset pulse too long");
	halt_flags_a: assert property (s_halt |-> ##[1:2] (o_power_down_flag && !o_expiry_flag))
		else $error("halt did not set power down and clear expiry");
	wake_expiry_a: assert property (o_pc_sp_clear |-> ##[0:1] o_expiry_flag)
		else $error("halted overflow without expiry flag");
	wake_quiet_a: assert property (o_pc_sp_clear |-> !o_device_reset && o_power_down_flag)
		else $error("halted overflow caused full reset");
	preset_hold_a: assert property (o_port_preset |-> o_cpu_hold ##1 !o_port_preset)
		else $error("port preset without hold or too long");
	pin_hold_a: assert property (s_pin_low |-> o_cpu_hold)
		else $error("low reset pin did not hold the core");
	release_wait_a: assert property (s_release |=> o_cpu_hold [*8])
		else $error("core released without delay");
	fixed_reset_a: assert property ((i_pin_config == CFG_ALWAYS_RESET) [*5] |-> o_shared_pin_is_reset)
		else $error("fixed reset option not applied");
	fixed_gpio_a: assert property ((i_pin_config == CFG_ALWAYS_GPIO) [*5] |-> !o_shared_pin_is_reset)
		else $error("fixed io option not applied");
endmodule

bind wdr_watchdog_reset_control wdr_monitor wdr_monitor_inst (
	.i_clock, .i_rst_n, .i_cpu_evt, .i_external_clear_pin_n, .i_pin_config,
	.o_device_reset, .o_pc_sp_clear, .o_cpu_hold, .o_port_preset,
	.o_shared_pin_is_reset, .o_expiry_flag, .o_power_down_flag
);

// [bench/wdr_cpu_model.sv]
// CPU core stand-in: turns bench requests into one-cycle instruction strobes.
// Assumes requests last one cycle on i_clock.
`timescale 1ns/100ps
module wdr_cpu_model
	import wdr_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_rst_n,
	// Bench and block side
	input  wire wdr_pkg::wdr_cpu_evt_s i_req,
	input  wire logic                  i_cpu_hold,
	output      wdr_pkg::wdr_cpu_evt_s o_evt
);
	// A held core executes nothing, so no strobe escapes then
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_evt <= '0;
		end else begin
			o_evt <= i_cpu_hold ? '0 : i_req;
		end
	end
endmodule

// [bench/tb_wdr_watchdog_reset_control.sv]
// Self-checking bench for the watchdog and reset control block.
// Assumes package, design, checker and core model are compiled first.
`timescale 1ns/100ps
module tb_wdr_watchdog_reset_control;
	import wdr_pkg::*;
	// ======
	// Signals
	logic         i_clock = 1'b0;
	logic         i_rst_n = 1'b0;
	logic         osc = 1'b0;
	logic         pin_n = 1'b1;
	logic [1:0]   cfg = 2'h0;
	logic         brown = 1'b0;
	logic         level = 1'b0;
	wdr_avs_req_s avs = '0;
	wdr_avs_rsp_s rsp;
	wdr_cpu_evt_s req = '0;
	wdr_cpu_evt_s evt;
	logic         dev_rst, pcsp, hold, preset, pin_rst, expiry, pdown;
	logic [7:0]   q;
	int           t;
	int           n_mismatch = 0;
	int           n_checks = 0;

	wdr_watchdog_reset_control wdr_watchdog_reset_control_inst (
		.i_clock, .i_rst_n, .i_avs(avs), .o_avs(rsp), .i_cpu_evt(evt),
		.i_brownout_event(brown), .i_level_code_event(level), .i_slow_internal_osc(osc),
		.i_external_clear_pin_n(pin_n), .i_pin_config(cfg), .o_device_reset(dev_rst),
		.o_pc_sp_clear(pcsp), .o_cpu_hold(hold), .o_port_preset(preset),
		.o_shared_pin_is_reset(pin_rst), .o_expiry_flag(expiry), .o_power_down_flag(pdown));
	wdr_cpu_model wdr_cpu_model_inst (.i_clock, .i_rst_n, .i_req(req), .i_cpu_hold(hold),
		.o_evt(evt));

	initial forever #20 i_clock = ~i_clock;
	// Slow clock sped up to four system cycles, unrelated phase
	initial begin
		#13;
		forever #80 osc = ~osc;
	end

	// ======
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Request stands until waitrequest is seen low at a rising edge, then released there
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge i_clock);
		avs <= '{a, !w, w, {24'h0, d}, 4'hF};
		do begin
			@(posedge i_clock);
			n++;
		end while (rsp.waitrequest && n < 20);
		q = rsp.readdata[7:0];
		avs.read <= 1'b0;
		avs.write <= 1'b0;
		if (rsp.waitrequest) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
		bus(a, 1'b0, 8'h00);
		chk(nm, q, e);
	endtask
	task automatic cpu(input wdr_cpu_evt_s e);
		@(posedge i_clock);
		req <= e;
		@(posedge i_clock);
		req <= '0;
	endtask
	// Select 0 device reset, 1 wake clear, 2 hold released
	task automatic wait_hi(input int sel, input int lim, input logic must);
		t = 0;
		do begin
			@(negedge i_clock);
			t++;
		end while (!(sel == 0 ? dev_rst : sel == 1 ? pcsp : !hold) && t < lim);
		if (must && t >= lim) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask

	// ======
	// Scenarios
	task automatic t_por();
		rd(ADDR_WDT_CTRL, WDT_CTRL_POR, "ctrl");
		rd(ADDR_PIN_KEY, PIN_KEY_POR, "pin key");
		bus(4'h2, 1'b1, 8'hFF);
		rd(4'h2, 8'h00, "unmapped");
		@(posedge i_clock);
		brown <= 1'b1;
		level <= 1'b1;
		@(posedge i_clock);
		brown <= 1'b0;
		level <= 1'b0;
		rd(ADDR_FLAGS, 8'h06, "flags events");
		bus(ADDR_FLAGS, 1'b1, 8'hFF);
		rd(ADDR_FLAGS, 8'h0F, "flags upper");
		bus(ADDR_FLAGS, 1'b1, 8'h00);
		rd(ADDR_FLAGS, 8'h00, "flags cleared");
		$display("por done");
	endtask
	task automatic t_period();
		int bits [8] = '{8, 10, 12, 14, 15, 16, 17, 18};
		for (int c = 0; c < 8; c++) begin
			bus(ADDR_WDT_CTRL, 1'b1, {KEY_ENABLE, 3'(c)});
			cpu(3'b100);
			wait_hi(0, c < 3 ? (4 << bits[c]) + 40 : 5000, c < 3);
			if (c < 3) begin
				chk("period", t > (4 << bits[c]) - 24 && t < (4 << bits[c]) + 24, 1);
				// Flag copy lags the reset pulse by one cycle
				@(negedge i_clock);
				chk("expiry", expiry, 1'b1);
			end else begin
				chk("long period", t, 5000);
			end
		end
		$display("period done");
	endtask
	task automatic t_disable();
		bus(ADDR_WDT_CTRL, 1'b1, {KEY_DISABLE, 3'h0});
		wait_hi(0, 1500, 1'b0);
		chk("disabled", t, 1500);
		bus(ADDR_WDT_CTRL, 1'b1, {KEY_ENABLE, 3'h0});
		wait_hi(0, 1200, 1'b1);
		chk("held at zero", t > 1000, 1);
		bus(ADDR_WDT_CTRL, 1'b1, {KEY_ENABLE, 3'h0});
		for (int i = 0; i < 3; i++) begin
			wait_hi(0, 700, 1'b0);
			chk("clear instr", t, 700);
			cpu(3'b100);
		end
		$display("disable done");
	endtask
	task automatic t_fault();
		bus(ADDR_WDT_CTRL, 1'b1, 8'h00);
		wait_hi(0, 400, 1'b1);
		chk("soft delay", t >= 4 * SOFT_RESET_TICKS - 8, 1);
		rd(ADDR_FLAGS, 8'h01, "key fault");
		rd(ADDR_WDT_CTRL, WDT_CTRL_POR, "ctrl restored");
		bus(ADDR_PIN_KEY, 1'b1, 8'h12);
		wait_hi(0, 400, 1'b1);
		rd(ADDR_FLAGS, 8'h09, "pin fault");
		rd(ADDR_PIN_KEY, PIN_KEY_POR, "pin key restored");
		bus(ADDR_FLAGS, 1'b1, 8'h00);
		rd(ADDR_FLAGS, 8'h00, "faults cleared");
		$display("fault done");
	endtask
	task automatic t_halt();
		bus(ADDR_PIN_KEY, 1'b1, PIN_CODE_RESET);
		bus(ADDR_WDT_CTRL, 1'b1, {KEY_ENABLE, 3'h0});
		cpu(3'b010);
		repeat (3) @(negedge i_clock);
		chk("power down", pdown, 1'b1);
		chk("expiry cleared", expiry, 1'b0);
		rd(ADDR_STATUS, 8'h06, "status halted");
		cpu(3'b001);
		rd(ADDR_STATUS, 8'h02, "status woken");
		// Count builds up, so a halt that fails to clear it shows as an early wake
		repeat (400) @(negedge i_clock);
		cpu(3'b010);
		wait_hi(1, 1200, 1'b1);
		@(negedge i_clock);
		chk("halt clears count", t > 1000, 1);
		chk("wake expiry", expiry, 1'b1);
		rd(ADDR_WDT_CTRL, {KEY_ENABLE, 3'h0}, "ctrl kept");
		rd(ADDR_PIN_KEY, PIN_CODE_RESET, "pin key kept");
		cpu(3'b001);
		bus(ADDR_WDT_CTRL, 1'b1, {KEY_DISABLE, 3'h0});
		$display("halt done");
	endtask
	task automatic t_pin();
		@(posedge i_clock);
		cfg <= 2'h2;
		bus(ADDR_PIN_KEY, 1'b1, PIN_CODE_RESET);
		repeat (4) @(negedge i_clock);
		chk("reg mode reset", pin_rst, 1'b1);
		bus(ADDR_PIN_KEY, 1'b1, PIN_CODE_GPIO);
		repeat (4) @(negedge i_clock);
		chk("reg mode io", pin_rst, 1'b0);
		@(posedge i_clock);
		cfg <= CFG_ALWAYS_RESET;
		bus(ADDR_PIN_KEY, 1'b1, PIN_CODE_RESET);
		repeat (6) @(negedge i_clock);
		chk("fixed reset", pin_rst, 1'b1);
		@(posedge i_clock);
		pin_n <= 1'b0;
		repeat (8) @(negedge i_clock);
		chk("pin hold", hold, 1'b1);
		@(posedge i_clock);
		pin_n <= 1'b1;
		wait_hi(2, 3000, 1'b1);
		chk("release delay", t >= PIN_RELEASE_CYCLES && t < PIN_RELEASE_CYCLES + 8, 1);
		rd(ADDR_WDT_CTRL, {KEY_DISABLE, 3'h0}, "ctrl survives");
		rd(ADDR_PIN_KEY, PIN_KEY_POR, "pin key por");
		@(posedge i_clock);
		cfg <= CFG_ALWAYS_GPIO;
		repeat (6) @(negedge i_clock);
		chk("fixed io", pin_rst, 1'b0);
		$display("pin done");
	endtask

	initial begin
		repeat (19) @(posedge i_clock);
		chk("preset", preset, 1'b1);
		chk("hold", hold, 1'b1);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		t_por();
		t_period();
		t_disable();
		t_fault();
		t_halt();
		t_pin();
		report_and_stop();
	end
endmodule
